// *** rtl/plc_device.sv ***
// Synthesizer control end: power states, lock detect, slip and boost timing.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module plc_device (
    plc_link_if.device link,
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic comp_tick,
    input wire logic [plc_pkg::ERR_W-1:0] main_phase_err_ns,
    input wire logic [plc_pkg::ERR_W-1:0] aux_phase_err_ns,
    output logic main_powered,
    output logic aux_powered,
    output logic pump_boost,
    output logic boost_shunt_resistor,
    output logic [4:0] comp_divide
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic ce_meta, ce_sync;
    logic dw_meta, dw_sync, dw_last;
    logic [1:0] tick_meta;
    logic tick_sync, tick_last;
    logic divider_event;
    logic ce_now;

    // Two stages on the chip enable and divider write pins from the host
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ce_meta <= 1'b0;
            ce_sync <= 1'b0;
            dw_meta <= 1'b0;
            dw_sync <= 1'b0;
            dw_last <= 1'b0;
            tick_meta <= 2'b00;
            tick_sync <= 1'b0;
            tick_last <= 1'b0;
        end else begin
            ce_meta <= link.chip_enable;
            ce_sync <= ce_meta;
            dw_meta <= link.divider_write;
            dw_sync <= dw_meta;
            dw_last <= dw_sync;
            tick_meta <= {tick_meta[0], comp_tick};
            tick_sync <= tick_meta[1];
            tick_last <= tick_sync;
        end
    end
    // Either direction of the toggle marks one divider write
    assign divider_event = dw_sync != dw_last;
    // Raw pin only gates outputs off; no power-up decided from it
    assign ce_now = link.chip_enable && ce_sync;

    // ****************************************************************
    // Power state
    // ****************************************************************
    logic auto_up;

    // Auto power-up latched on divider write, cleared by chip enable low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            auto_up <= 1'b0;
        end else if (!ce_sync) begin
            auto_up <= 1'b0;
        end else if (divider_event && link.auto_power_up) begin
            auto_up <= 1'b1;
        end else if (!link.main_loop_power_down) begin
            auto_up <= 1'b0;
        end
    end

    logic main_on_reg, aux_on_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            main_on_reg <= 1'b0;
            aux_on_reg <= 1'b0;
        end else begin
            main_on_reg <= ce_sync && (!link.main_loop_power_down || auto_up);
            aux_on_reg <= ce_sync && !link.aux_loop_power_down;
        end
    end
    // Power-down gated combinationally so it never waits on a clock edge
    assign main_powered = main_on_reg && ce_now && (!link.main_loop_power_down || auto_up);
    assign aux_powered = aux_on_reg && ce_now && !link.aux_loop_power_down;

    // ****************************************************************
    // Lock detect with optional divide-by-4
    // ****************************************************************
    logic [1:0] pre_count;
    logic comp_edge, ld_tick;
    assign comp_edge = tick_sync && !tick_last;

    // Prescale of comparison ticks seen by the detector
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_count <= 2'h0;
        end else if (divider_event) begin
            pre_count <= 2'h0;
        end else if (comp_edge) begin
            pre_count <= pre_count + 2'h1;
        end
    end
    assign ld_tick = comp_edge && (!link.lock_detect_prescale || pre_count == 2'(plc_pkg::LD_PRESCALE_DIV - 1));

    logic main_locked, aux_locked;
    plc_lock_det #(.ACQ_NS(plc_pkg::MAIN_ACQ_NS), .REL_NS(plc_pkg::MAIN_REL_NS)) u_main_ld (
        .mclk(mclk),
        .rst_b(rst_b),
        .restart(divider_event || !main_on_reg),
        .ref_tick(ld_tick),
        .phase_err_ns(main_phase_err_ns),
        .locked(main_locked)
    );
    plc_lock_det #(.ACQ_NS(plc_pkg::AUX_ACQ_NS), .REL_NS(plc_pkg::AUX_REL_NS)) u_aux_ld (
        .mclk(mclk),
        .rst_b(rst_b),
        .restart(divider_event || !aux_on_reg),
        .ref_tick(ld_tick),
        .phase_err_ns(aux_phase_err_ns),
        .locked(aux_locked)
    );

    // Test output: powered-down loop shows unlocked
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link.multipurpose_test_output <= 1'b0;
        end else begin
            case (link.test_output_select)
                plc_pkg::TSEL_MAIN_LOCK: link.multipurpose_test_output <= main_locked && main_on_reg;
                plc_pkg::TSEL_AUX_LOCK: link.multipurpose_test_output <= aux_locked && aux_on_reg;
                plc_pkg::TSEL_BOTH_LOCK: begin
                    link.multipurpose_test_output <= main_locked && aux_locked && main_on_reg && aux_on_reg;
                end
                default: link.multipurpose_test_output <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Slip reduction and acquisition boost timeout
    // ****************************************************************
    logic [15:0] timeout_left;
    logic assist_active;

    // Started by divider write, counted in comparison ticks
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_left <= 16'h0000;
            assist_active <= 1'b0;
        end else if (!main_on_reg) begin
            timeout_left <= 16'h0000;
            assist_active <= 1'b0;
        end else if (divider_event) begin
            timeout_left <= link.timeout_count;
            assist_active <= (link.timeout_count != 16'h0000);
        end else if (assist_active && comp_edge) begin
            timeout_left <= timeout_left - 16'h0001;
            if (timeout_left == 16'h0001) begin
                assist_active <= 1'b0;
            end
        end
    end

    // Assist outputs, registered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pump_boost <= 1'b0;
            boost_shunt_resistor <= 1'b0;
            comp_divide <= 5'h01;
        end else begin
            pump_boost <= assist_active && link.boost_enable;
            boost_shunt_resistor <= assist_active && link.boost_enable;
            if (assist_active && link.slip_enable) begin
                case (link.slip_reduction)
                    plc_pkg::SLIP_DIV2: comp_divide <= 5'h02;
                    plc_pkg::SLIP_LOCK_DETECT_PRESCALE: comp_divide <= 5'h04;
                    plc_pkg::SLIP_DIV16: comp_divide <= 5'h10;
                    default: comp_divide <= 5'h01;
                endcase
            end else begin
                comp_divide <= 5'h01;
            end
        end
    end
endmodule : plc_device

// *** rtl/plc_pkg.sv ***
// Constants shared by the synthesizer control ends and their link.
package plc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOCK_CONSEC_CYCLES = 5;
    localparam int MAIN_ACQ_NS = 10;
    localparam int MAIN_REL_NS = 20;
    localparam int AUX_ACQ_NS = 15;
    localparam int AUX_REL_NS = 30;
    localparam int ERR_W = 8;
    localparam int LD_PRESCALE_DIV = 4;

    // ****************************************************************
    // APB register map of the host controller
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIVIDER = 8'h04;
    localparam logic [7:0] REG_TIMEOUT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;

    // Control field positions
    localparam int CTRL_MAIN_PD = 0;
    localparam int CTRL_AUX_PD = 1;
    localparam int CTRL_AUTO_PU = 2;
    localparam int CTRL_PRESCALE = 3;
    localparam int CTRL_SLIP_EN = 4;
    localparam int CTRL_BOOST_EN = 5;
    localparam int CTRL_SLIP_SEL = 6;
    localparam int CTRL_TSEL = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0010;

    // Slip factor codes
    localparam logic [1:0] SLIP_DIV2 = 2'h0;
    localparam logic [1:0] SLIP_LOCK_DETECT_PRESCALE = 2'h1;
    localparam logic [1:0] SLIP_DIV16 = 2'h2;

    // Test output selections
    localparam logic [3:0] TSEL_LOW = 4'h0;
    localparam logic [3:0] TSEL_MAIN_LOCK = 4'h1;
    localparam logic [3:0] TSEL_AUX_LOCK = 4'h2;
    localparam logic [3:0] TSEL_BOTH_LOCK = 4'h3;

    // Lock detector states
    typedef enum logic [1:0] {
        PLC_LD_IDLE = 2'b00,
        PLC_LD_QUAL = 2'b01,
        PLC_LD_LOCKED = 2'b10
    } plc_ld_state_type;

endpackage : plc_pkg

// *** rtl/plc_link_if.sv ***
// Link between the host controller and the synthesizer control logic.
`timescale 1ns/100ps
interface plc_link_if;
    logic chip_enable;
    logic main_loop_power_down;
    logic aux_loop_power_down;
    logic auto_power_up;
    logic lock_detect_prescale;
    logic slip_enable;
    logic boost_enable;
    logic [1:0] slip_reduction;
    logic [3:0] test_output_select;
    logic [15:0] timeout_count;
    logic [23:0] main_divider_word;
    logic divider_write;
    logic multipurpose_test_output;

    modport device (
        input chip_enable, main_loop_power_down, aux_loop_power_down, auto_power_up,
        input lock_detect_prescale, slip_enable, boost_enable, slip_reduction,
        input test_output_select, timeout_count, main_divider_word, divider_write,
        output multipurpose_test_output
    );
    modport host (
        output chip_enable, main_loop_power_down, aux_loop_power_down, auto_power_up,
        output lock_detect_prescale, slip_enable, boost_enable, slip_reduction,
        output test_output_select, timeout_count, main_divider_word, divider_write,
        input multipurpose_test_output
    );
endinterface : plc_link_if

// *** rtl/plc_lock_det.sv ***
// Digital lock detector with acquire and release thresholds.
`timescale 1ns/100ps
module plc_lock_det #(
    parameter int ACQ_NS = 10,
    parameter int REL_NS = 20
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic ref_tick,
    input wire logic [plc_pkg::ERR_W-1:0] phase_err_ns,
    output logic locked
);
    // Thresholds must be ordered and fit the error width; the qualify count is 3 bits
    if (REL_NS <= ACQ_NS || REL_NS >= (1 << plc_pkg::ERR_W) || plc_pkg::LOCK_CONSEC_CYCLES < 1
        || plc_pkg::LOCK_CONSEC_CYCLES > 8) begin : g_bad_setup
        $error("plc_lock_det: thresholds or cycle count out of range");
    end

    localparam logic [plc_pkg::ERR_W-1:0] ACQ = plc_pkg::ERR_W'(ACQ_NS);
    localparam logic [plc_pkg::ERR_W-1:0] REL = plc_pkg::ERR_W'(REL_NS);

    plc_pkg::plc_ld_state_type state;
    logic [2:0] count;

    // Qualification and hysteresis, evaluated once per reference tick
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= plc_pkg::PLC_LD_IDLE;
            count <= 3'h0;
        end else if (restart) begin
            state <= plc_pkg::PLC_LD_IDLE;
            count <= 3'h0;
        end else if (ref_tick) begin
            case (state)
                plc_pkg::PLC_LD_IDLE, plc_pkg::PLC_LD_QUAL: begin
                    if (phase_err_ns >= ACQ) begin
                        state <= plc_pkg::PLC_LD_IDLE;
                        count <= 3'h0;
                    end else if (count == 3'(plc_pkg::LOCK_CONSEC_CYCLES - 1)) begin
                        state <= plc_pkg::PLC_LD_LOCKED;
                        count <= 3'h0;
                    end else begin
                        state <= plc_pkg::PLC_LD_QUAL;
                        count <= count + 3'h1;
                    end
                end
                plc_pkg::PLC_LD_LOCKED: begin
                    if (phase_err_ns > REL) begin
                        state <= plc_pkg::PLC_LD_IDLE;
                    end
                end
                default: state <= plc_pkg::PLC_LD_IDLE;
            endcase
        end
    end

    assign locked = (state == plc_pkg::PLC_LD_LOCKED);
endmodule : plc_lock_det

// *** rtl/plc_host.sv ***
// Host controller: APB registers driving the synthesizer control link.
`timescale 1ns/100ps
module plc_host (
    plc_link_if.host link,
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic chip_enable_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata
);
    logic [31:0] ctrl;
    logic [15:0] timeout;
    logic lock_meta, lock_sync;
    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // Control registers; software settings sane
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= plc_pkg::CTRL_RESET;
            timeout <= plc_pkg::TIMEOUT_RESET;
            link.main_divider_word <= 24'h00_0000;
            link.divider_write <= 1'b0;
        end else begin
            if (wr && paddr == plc_pkg::REG_CTRL) begin
                ctrl <= pwdata;
            end
            if (wr && paddr == plc_pkg::REG_TIMEOUT) begin
                timeout <= pwdata[15:0];
            end
            if (wr && paddr == plc_pkg::REG_DIVIDER) begin
                link.main_divider_word <= pwdata[23:0];
                link.divider_write <= ~link.divider_write; // Toggle marks each write
            end
        end
    end

    // Chip enable pin driven from a flop; test output synchronised for status
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link.chip_enable <= 1'b0;
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
        end else begin
            link.chip_enable <= chip_enable_in;
            lock_meta <= link.multipurpose_test_output;
            lock_sync <= lock_meta;
        end
    end

    assign link.main_loop_power_down = ctrl[plc_pkg::CTRL_MAIN_PD];
    assign link.aux_loop_power_down = ctrl[plc_pkg::CTRL_AUX_PD];
    assign link.auto_power_up = ctrl[plc_pkg::CTRL_AUTO_PU];
    assign link.lock_detect_prescale = ctrl[plc_pkg::CTRL_PRESCALE];
    assign link.slip_enable = ctrl[plc_pkg::CTRL_SLIP_EN];
    assign link.boost_enable = ctrl[plc_pkg::CTRL_BOOST_EN];
    assign link.slip_reduction = ctrl[plc_pkg::CTRL_SLIP_SEL +: 2];
    assign link.test_output_select = ctrl[plc_pkg::CTRL_TSEL +: 4];
    assign link.timeout_count = timeout;

    // APB answer: zero wait states, unmapped reads zero with error
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != plc_pkg::REG_CTRL && paddr != plc_pkg::REG_DIVIDER
                && paddr != plc_pkg::REG_TIMEOUT && paddr != plc_pkg::REG_STATUS;
            if (rd) begin
                case (paddr)
                    plc_pkg::REG_CTRL: prdata <= ctrl;
                    plc_pkg::REG_DIVIDER: prdata <= {8'h00, link.main_divider_word};
                    plc_pkg::REG_TIMEOUT: prdata <= {16'h0000, timeout};
                    plc_pkg::REG_STATUS: prdata <= {31'h0000_0000, lock_sync};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : plc_host

// *** test/plc_link_properties.sv ***
// Concurrent checks on the link between host controller and control logic.
`timescale 1ns/100ps
module plc_link_properties (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic chip_enable,
    input wire logic main_loop_power_down,
    input wire logic aux_loop_power_down,
    input wire logic auto_power_up,
    input wire logic lock_detect_prescale,
    input wire logic [3:0] test_output_select,
    input wire logic [15:0] timeout_count,
    input wire logic divider_write,
    input wire logic multipurpose_test_output
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic [7:0] since_div;

    // Cycles since the last divider toggle; saturates so it never wraps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            since_div <= 8'h00;
        end else if ($changed(divider_write)) begin
            since_div <= 8'h00;
        end else if (since_div != 8'hFF) begin
            since_div <= since_div + 8'h01;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_reset_values: assert property ($rose(rst_b) |-> main_loop_power_down && aux_loop_power_down
        && !auto_power_up && timeout_count == 16'h0010) else $error("link reset values wrong");
    a_ce_low_dark: assert property ((!chip_enable)[*5] |-> !multipurpose_test_output)
        else $error("output high while chip disabled");
    a_aux_pd_dark: assert property ((aux_loop_power_down
        && test_output_select == plc_pkg::TSEL_AUX_LOCK)[*5] |-> !multipurpose_test_output)
        else $error("aux lock high while aux powered down");
    a_both_needs_aux: assert property ((aux_loop_power_down
        && test_output_select == plc_pkg::TSEL_BOTH_LOCK)[*5] |-> !multipurpose_test_output)
        else $error("combined lock high with aux unlocked");
    a_restart_drops: assert property ($changed(divider_write)
        && test_output_select != plc_pkg::TSEL_LOW |-> ##5 (!multipurpose_test_output)[*4])
        else $error("lock kept across divider write");
    a_sel_low_quiet: assert property ((test_output_select == plc_pkg::TSEL_LOW)[*3]
        |-> !multipurpose_test_output) else $error("output high with low selection");
    a_lock_min_wait: assert property ($rose(multipurpose_test_output) |-> since_div > 8'h08)
        else $error("lock too soon after restart");
    a_lock_prescaled: assert property ($rose(multipurpose_test_output) && lock_detect_prescale
        |-> since_div > 8'h24) else $error("prescaled lock too soon");

    c_lock_seen: cover property ($rose(multipurpose_test_output));
    c_restart: cover property ($changed(divider_write));
    c_both_lock: cover property (test_output_select == plc_pkg::TSEL_BOTH_LOCK && multipurpose_test_output);
endmodule : plc_link_properties

// *** test/tb_pll_lock_detect_power_ctl.sv ***
// Self-checking bench joining host controller and control logic.
`timescale 1ns/100ps
module tb_pll_lock_detect_power_ctl;
    logic mclk, rst_b, chip_enable_in, psel, penable, pwrite, pready, pslverr, rd_err, comp_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic [plc_pkg::ERR_W-1:0] main_err, aux_err;
    logic main_powered, aux_powered, pump_boost, boost_shunt_resistor;
    logic [4:0] comp_divide;
    int num_errors, cmp_count;

    // ****************************************************************
    // Structure
    // ****************************************************************
    plc_link_if link ();
    plc_host plc_host_i (.link(link), .mclk(mclk), .rst_b(rst_b), .chip_enable_in(chip_enable_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata));
    plc_device plc_device_i (.link(link), .mclk(mclk), .rst_b(rst_b), .comp_tick(comp_tick),
        .main_phase_err_ns(main_err), .aux_phase_err_ns(aux_err), .main_powered(main_powered),
        .aux_powered(aux_powered), .pump_boost(pump_boost), .boost_shunt_resistor(boost_shunt_resistor),
        .comp_divide(comp_divide));
    plc_link_properties plc_link_properties_i (.mclk(mclk), .rst_b(rst_b),
        .chip_enable(link.chip_enable), .main_loop_power_down(link.main_loop_power_down),
        .aux_loop_power_down(link.aux_loop_power_down), .auto_power_up(link.auto_power_up),
        .lock_detect_prescale(link.lock_detect_prescale), .test_output_select(link.test_output_select),
        .timeout_count(link.timeout_count), .divider_write(link.divider_write),
        .multipurpose_test_output(link.multipurpose_test_output));

    // 20 MHz clock
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    // Lock output as seen through the status register
    task st(input logic e);
        repeat (4) @(posedge mclk);
        apb(1'b0, plc_pkg::REG_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, rd_val[0]}, {31'h0000_0000, e});
    endtask : st

    // Comparison ticks slow enough for the three-flop synchroniser
    task tickn(input int n);
        repeat (n) begin
            comp_tick <= 1'b1;
            repeat (3) @(posedge mclk);
            comp_tick <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask : tickn

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        apb(1'b0, plc_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd_val, 32'h0000_0003);
        apb(1'b0, plc_pkg::REG_TIMEOUT, 32'h0000_0000);
        chk(rd_val, 32'h0000_0010);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({rd_err, rd_val[30:0]}, 32'h8000_0000);
        chk({31'h0000_0000, main_powered}, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task t_main_lock;
        wr(plc_pkg::REG_CTRL, 32'h0000_0100);
        main_err <= 8'h05;
        wr(plc_pkg::REG_DIVIDER, 32'h0000_0123);
        tickn(4);
        st(1'b0);
        main_err <= 8'h0A;
        tickn(1);
        main_err <= 8'h05;
        tickn(4);
        st(1'b0);
        tickn(1);
        st(1'b1);
        main_err <= 8'h14;
        tickn(3);
        st(1'b1);
        main_err <= 8'h15;
        tickn(1);
        st(1'b0);
        $display("test main lock done");
    endtask : t_main_lock

    task t_aux_lock;
        wr(plc_pkg::REG_CTRL, 32'h0000_0200);
        main_err <= 8'h32;
        aux_err <= 8'h0E;
        wr(plc_pkg::REG_DIVIDER, 32'h0000_0124);
        tickn(5);
        st(1'b1);
        aux_err <= 8'h1E;
        tickn(2);
        st(1'b1);
        aux_err <= 8'h1F;
        tickn(1);
        st(1'b0);
        aux_err <= 8'h0E;
        tickn(5);
        wr(plc_pkg::REG_CTRL, 32'h0000_0300);
        st(1'b0);
        main_err <= 8'h05;
        tickn(5);
        st(1'b1);
        $display("test aux lock done");
    endtask : t_aux_lock

    task t_power;
        wr(plc_pkg::REG_CTRL, 32'h0000_0302);
        st(1'b0);
        chk({30'h0000_0000, main_powered, aux_powered}, 32'h0000_0002);
        wr(plc_pkg::REG_CTRL, 32'h0000_0202);
        st(1'b0);
        // Main lock shown first so that chip enable low has something to drop
        wr(plc_pkg::REG_CTRL, 32'h0000_0100);
        st(1'b1);
        chip_enable_in <= 1'b0;
        @(posedge mclk);
        #1;
        chk({30'h0000_0000, main_powered, aux_powered}, 32'h0000_0000);
        repeat (4) @(posedge mclk);
        st(1'b0);
        chip_enable_in <= 1'b1;
        repeat (4) @(posedge mclk);
        $display("test power done");
    endtask : t_power

    task t_auto_pu;
        wr(plc_pkg::REG_CTRL, 32'h0000_0105);
        repeat (4) @(posedge mclk);
        chk({31'h0000_0000, main_powered}, 32'h0000_0000);
        wr(plc_pkg::REG_DIVIDER, 32'h0000_0125);
        repeat (6) @(posedge mclk);
        chk({31'h0000_0000, main_powered}, 32'h0000_0001);
        tickn(5);
        st(1'b1);
        $display("test auto power-up done");
    endtask : t_auto_pu

    task t_prescale;
        wr(plc_pkg::REG_CTRL, 32'h0000_0108);
        wr(plc_pkg::REG_DIVIDER, 32'h0000_0126);
        tickn(19);
        st(1'b0);
        tickn(1);
        st(1'b1);
        $display("test prescale done");
    endtask : t_prescale

    task t_assist;
        logic [31:0] exp_div [3];
        exp_div = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0010};
        wr(plc_pkg::REG_TIMEOUT, 32'h0000_0008);
        for (int i = 0; i < 3; i++) begin
            // Slip reduction alone, boost kept off
            wr(plc_pkg::REG_CTRL, 32'h0000_0110 | (i << plc_pkg::CTRL_SLIP_SEL));
            wr(plc_pkg::REG_DIVIDER, 32'h0000_0127);
            repeat (6) @(posedge mclk);
            chk({27'h000_0000, comp_divide}, exp_div[i]);
            // Timeout of 8 ticks: engaged after 7, released by the 8th
            tickn(7);
            chk({27'h000_0000, comp_divide}, exp_div[i]);
            tickn(1);
            chk({27'h000_0000, comp_divide}, 32'h0000_0001);
        end
        wr(plc_pkg::REG_CTRL, 32'h0000_0120);
        wr(plc_pkg::REG_DIVIDER, 32'h0000_0128);
        repeat (6) @(posedge mclk);
        chk({30'h0000_0000, pump_boost, boost_shunt_resistor}, 32'h0000_0003);
        tickn(7);
        chk({30'h0000_0000, pump_boost, boost_shunt_resistor}, 32'h0000_0003);
        tickn(1);
        chk({30'h0000_0000, pump_boost, boost_shunt_resistor}, 32'h0000_0000);
        $display("test assist done");
    endtask : t_assist

    // ****************************************************************
    // Verdict and control
    // ****************************************************************
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Main sequence after ten cycles of reset
    initial begin
        rst_b = 1'b0;
        chip_enable_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        comp_tick = 1'b0;
        main_err = 8'h32;
        aux_err = 8'h32;
        num_errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_main_lock;
        t_aux_lock;
        t_power;
        t_auto_pu;
        t_prescale;
        t_assist;
        complete_run;
    end

    // Watchdog well beyond the expected run of about 800 cycles
    initial begin
        repeat (10000) @(posedge mclk);
        num_errors++;
        complete_run;
    end
endmodule : tb_pll_lock_detect_power_ctl
